/* File: repeater_mgmt.sv */
// Purpose: Management status, actions and events of a baseband repeater
// Assumes: Classic Wishbone slave; presence pins asynchronous, core and fault inputs on clk_i
// Notes:   Collision counter clears only at rst_i, never through an action
//
// Notes on behaviour
// RQ1: Class code reads 9, 271, 272, other, unknown
// RQ2: Groups numbered one up to group capacity
// RQ3: Group bitmap, bit zero is group one
// RQ4: Health reports highest priority failure present
// RQ5: Health text 255 printable, data 0-255 octets
// RQ6: Ten Mb/s: count collision entry not from one-left
// RQ7: Hundred Mb/s: count jam from multiple active
// RQ8: Collision counter nonresettable, fast enough
// RQ9: Reset action restarts core, runs disruptive test
// RQ10: During test no transmit, management keeps working
// RQ11: Reset event at power-on and action completion
// RQ12: Safe self-test changes nothing, then health event
// RQ13: Health event only on change, not power-up
// RQ14: Health event carries health value
// RQ15: Reset event carries health value
// RQ16: Group event on add or remove, not power-up
// RQ17: Group identifiers unique, within capacity
// RQ18: Port capacity within 1 to 1024, ports numbered
// RQ19: Port bitmap per group, one bit per port
// RQ20: Counter wraps, untouched by actions and tests
`include "repeater_mgmt_cfg.svh"

module repeater_mgmt (
	input  wire logic                                    clk_i,
	input  wire logic                                    rst_i,
	input  wire logic [11:0]                             adr_i,
	input  wire logic [31:0]                             dat_i,
	input  wire logic [3:0]                              sel_i,
	input  wire logic                                    we_i,
	input  wire logic                                    cyc_i,
	input  wire logic                                    stb_i,
	output logic      [31:0]                             dat_o,
	output logic                                         ack_o,
	input  wire repeater_mgmt_pkg::class_sel_e           class_sel_i,
	input  wire logic [`GROUP_CAP-1:0]                   group_present_i,
	input  wire logic [`GROUP_CAP*`PORT_CAP-1:0]         port_present_i,
	input  wire repeater_mgmt_pkg::fault_s               fault_i,
	input  wire repeater_mgmt_pkg::core_s                core_i,
	output logic                                         core_restart_o,
	output logic                                         tx_inhibit_o,
	output logic                                         selftest_busy_o,
	output repeater_mgmt_pkg::event_s                    event_o
);

	// ----------------------------------------------------------------
	// Types and state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_DISRUPT = 3'b010,
		ST_SAFE    = 3'b100
	} test_state_e;

	localparam logic [16:0] DISRUPT_LAST = 17'(`DISRUPT_CYCLES - 1);
	localparam logic [16:0] SAFE_LAST    = 17'(`SAFE_CYCLES - 1);

	test_state_e                         state_reg;
	logic [16:0]                         timer_reg;
	logic [1:0]                          init_reg;
	logic [`GROUP_CAP-1:0]               grp_meta_reg;
	logic [`GROUP_CAP-1:0]               grp_sync_reg;
	logic [`GROUP_CAP*`PORT_CAP-1:0]     port_meta_reg;
	logic [`GROUP_CAP*`PORT_CAP-1:0]     port_sync_reg;
	logic [`GROUP_CAP-1:0]               group_map_reg;
	repeater_mgmt_pkg::health_e          health_reg;
	repeater_mgmt_pkg::health_e          health_next;
	logic [31:0]                         coll_count_reg;
	logic [7:0]                          text_len_reg;
	logic [7:0]                          data_len_reg;
	logic [7:0]                          text_mem [0:255];
	logic [7:0]                          data_mem [0:255];
	logic                                ready;
	logic                                req;
	logic                                wr;
	logic                                coll_inc;
	logic                                disrupt_done;
	logic                                safe_done;
	logic [31:0]                         rd_data;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic repeater_mgmt_pkg::health_e pick_health(
		input repeater_mgmt_pkg::fault_s f);
		if (f.repeater_fail) begin
			return repeater_mgmt_pkg::HEALTH_REPEATER;
		end else if (f.group_fail) begin
			return repeater_mgmt_pkg::HEALTH_GROUP;
		end else if (f.port_fail) begin
			return repeater_mgmt_pkg::HEALTH_PORT;
		end else if (f.general_fail) begin
			return repeater_mgmt_pkg::HEALTH_GENERAL;
		end else if (f.unknown) begin
			return repeater_mgmt_pkg::HEALTH_OTHER;
		end
		return repeater_mgmt_pkg::HEALTH_OK;
	endfunction

	function automatic logic [31:0] class_code(input repeater_mgmt_pkg::class_sel_e s);
		unique case (s)
			repeater_mgmt_pkg::CLASS_SEL_TEN:   return `CLASS_TEN;
			repeater_mgmt_pkg::CLASS_SEL_FAST1: return `CLASS_FAST_ONE;
			repeater_mgmt_pkg::CLASS_SEL_FAST2: return `CLASS_FAST_TWO;
			repeater_mgmt_pkg::CLASS_SEL_OTHER: return `CLASS_OTHER;
			default:                            return `CLASS_UNKNOWN;
		endcase
	endfunction

	function automatic logic printable(input logic [7:0] c);
		return (c >= `PRINT_LOW) && (c <= `PRINT_HIGH);
	endfunction

	assign health_next  = pick_health(fault_i);  // [RQ4]
	assign ready        = (init_reg == 2'h3);
	assign req          = cyc_i && stb_i && !ack_o;
	assign wr           = req && we_i && sel_i[0];
	assign disrupt_done = (state_reg == ST_DISRUPT) && (timer_reg == 17'h0);
	assign safe_done    = (state_reg == ST_SAFE) && (timer_reg == 17'h0);

	// ----------------------------------------------------------------
	// Presence synchronisers and power-up settling
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		grp_meta_reg  <= group_present_i;
		grp_sync_reg  <= grp_meta_reg;
		port_meta_reg <= port_present_i;
		port_sync_reg <= port_meta_reg;
	end

	// Health and group events stay quiet until the synchronisers hold real pin values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			init_reg <= 2'h0;
		end else if (!ready) begin
			init_reg <= init_reg + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// Collision counter
	// ----------------------------------------------------------------
	always_comb begin
		if (class_sel_i == repeater_mgmt_pkg::CLASS_SEL_TEN) begin
			coll_inc = core_i.coll_enter && !core_i.from_one_left;  // [RQ6]
		end else if (class_sel_i == repeater_mgmt_pkg::CLASS_SEL_FAST1 ||
			class_sel_i == repeater_mgmt_pkg::CLASS_SEL_FAST2) begin
			coll_inc = core_i.jam_enter && core_i.multi_active;  // [RQ7]
		end else begin
			coll_inc = 1'b0;
		end
	end

	// One increment per cycle is far above the required event rate
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			coll_count_reg <= 32'h0;
		end else if (coll_inc) begin
			coll_count_reg <= coll_count_reg + 32'h1;  // [RQ8] [RQ20]
		end
	end

	// ----------------------------------------------------------------
	// Self-test sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			timer_reg <= 17'h0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (wr && adr_i == `OFS_ACTION && dat_i[`ACT_RESET_BIT]) begin
						state_reg <= ST_DISRUPT;  // [RQ9]
						timer_reg <= DISRUPT_LAST;
					end else if (wr && adr_i == `OFS_ACTION && dat_i[`ACT_SAFE_BIT]) begin
						state_reg <= ST_SAFE;  // [RQ12]
						timer_reg <= SAFE_LAST;
					end
				end
				ST_DISRUPT, ST_SAFE: begin
					if (timer_reg == 17'h0) begin
						state_reg <= ST_IDLE;
					end else begin
						timer_reg <= timer_reg - 17'h1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Core restart only on the accepting write; transmit held off through the disruptive test
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_restart_o  <= 1'b0;
			tx_inhibit_o    <= 1'b0;
			selftest_busy_o <= 1'b0;
		end else begin
			core_restart_o  <= (state_reg == ST_IDLE) && wr && adr_i == `OFS_ACTION &&
				dat_i[`ACT_RESET_BIT];  // [RQ9]
			tx_inhibit_o    <= (state_reg == ST_IDLE) ? (wr && adr_i == `OFS_ACTION &&
				dat_i[`ACT_RESET_BIT]) : (state_reg == ST_DISRUPT && !disrupt_done);  // [RQ10]
			selftest_busy_o <= (state_reg == ST_IDLE) ? (wr && adr_i == `OFS_ACTION &&
				dat_i[`ACT_RESET_BIT +: 2] != 2'h0) : !(disrupt_done || safe_done);
		end
	end

	// ----------------------------------------------------------------
	// Health, group map and events
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			health_reg    <= repeater_mgmt_pkg::HEALTH_OTHER;
			group_map_reg <= '0;
		end else begin
			health_reg    <= health_next;
			group_map_reg <= grp_sync_reg;  // [RQ3] [RQ2]
		end
	end

	// Events carry the value as it is after the change
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			event_o <= '{health_change_event: 1'b0, reset_done_event: 1'b0,
				group_layout_event: 1'b0, health_condition: repeater_mgmt_pkg::HEALTH_OTHER,
				group_presence_bitmap: '0};
		end else begin
			event_o.health_change_event   <= ready &&
				((health_next != health_reg) || safe_done);  // [RQ13] [RQ12]
			event_o.reset_done_event      <= (init_reg == 2'h2) || (ready && disrupt_done);  // [RQ11]
			event_o.group_layout_event    <= ready && (grp_sync_reg != group_map_reg);  // [RQ16]
			event_o.health_condition      <= health_next;  // [RQ14] [RQ15]
			event_o.group_presence_bitmap <= grp_sync_reg;
		end
	end

	// ----------------------------------------------------------------
	// Health text and data store
	// ----------------------------------------------------------------
	// Non-printable characters are dropped so the text stays displayable
	always_ff @(posedge clk_i) begin
		if (wr && adr_i[11:10] == `OFS_TEXT_BASE && printable(dat_i[7:0])) begin
			text_mem[adr_i[9:2]] <= dat_i[7:0];  // [RQ5]
		end
		if (wr && adr_i[11:10] == `OFS_DATA_BASE) begin
			data_mem[adr_i[9:2]] <= dat_i[7:0];  // [RQ5]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			text_len_reg <= 8'h0;
			data_len_reg <= 8'h0;
		end else begin
			if (wr && adr_i == `OFS_TEXT_LEN) begin
				text_len_reg <= (dat_i[7:0] > `TEXT_MAX) ? `TEXT_MAX : dat_i[7:0];  // [RQ5]
			end
			if (wr && adr_i == `OFS_DATA_LEN) begin
				data_len_reg <= dat_i[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Wishbone read path
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 32'h0;
		if (adr_i[11:10] == `OFS_TEXT_BASE) begin
			rd_data = {24'h0, text_mem[adr_i[9:2]]};
		end else if (adr_i[11:10] == `OFS_DATA_BASE) begin
			rd_data = {24'h0, data_mem[adr_i[9:2]]};
		end else if (adr_i[11:8] == `OFS_GROUP_BASE && adr_i[7:2] < 6'(`GROUP_CAP)) begin
			// Group identifier in the top half, port capacity in the bottom
			rd_data = {16'(adr_i[4:2]) + 16'h1, 16'(`PORT_CAP)};  // [RQ17] [RQ18]
		end else if (adr_i[11:8] == `OFS_PORTMAP_BASE && adr_i[7:2] < 6'(`GROUP_CAP)) begin
			rd_data = 32'(port_sync_reg[adr_i[4:2]*`PORT_CAP +: `PORT_CAP]);  // [RQ19]
		end else begin
			unique case (adr_i)
				`OFS_IDENT:      rd_data = `IDENT_VALUE;
				`OFS_CLASS:      rd_data = class_code(class_sel_i);  // [RQ1]
				`OFS_GROUP_CAP:  rd_data = 32'(`GROUP_CAP);  // [RQ2]
				`OFS_GROUP_MAP:  rd_data = 32'(group_map_reg);  // [RQ3]
				`OFS_HEALTH:     rd_data = 32'(health_reg);  // [RQ4]
				`OFS_TEXT_LEN:   rd_data = {24'h0, text_len_reg};
				`OFS_DATA_LEN:   rd_data = {24'h0, data_len_reg};
				`OFS_COLL_COUNT: rd_data = coll_count_reg;  // [RQ8]
				`OFS_STATUS:     rd_data = {29'h0, state_reg};
				default:         rd_data = 32'h0;
			endcase
		end
	end

	// Single wait state; management access continues during either test
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= req;  // [RQ10]
			dat_o <= req ? rd_data : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	health_prio_a: assert property (fault_i.repeater_fail |=>  // [RQ4]
		health_reg == repeater_mgmt_pkg::HEALTH_REPEATER)
		else $error("health priority wrong");

	coll_ten_a: assert property ((class_sel_i == repeater_mgmt_pkg::CLASS_SEL_TEN &&  // [RQ6]
		core_i.coll_enter && !core_i.from_one_left) |=>
		coll_count_reg == $past(coll_count_reg) + 32'h1)
		else $error("ten collision not counted");

	coll_jam_a: assert property ((class_sel_i == repeater_mgmt_pkg::CLASS_SEL_FAST1 &&  // [RQ7]
		core_i.jam_enter && !core_i.multi_active) |=> $stable(coll_count_reg))
		else $error("jam counted without contention");

	coll_keep_a: assert property ((state_reg != ST_IDLE && !coll_inc) |=>  // [RQ20]
		$stable(coll_count_reg))
		else $error("counter moved during test");

	tx_quiet_a: assert property ((state_reg == ST_DISRUPT && timer_reg != 17'h0) |->  // [RQ10]
		tx_inhibit_o)
		else $error("transmit during disruptive test");

	reset_evt_a: assert property (disrupt_done |=> event_o.reset_done_event &&  // [RQ11]
		event_o.health_condition == $past(health_next))
		else $error("reset event missing");

	powerup_evt_a: assert property ($fell(rst_i) |=> ##2 event_o.reset_done_event &&  // [RQ11]
		!event_o.health_change_event)
		else $error("power-on reset event missing");

	health_evt_a: assert property (event_o.health_change_event |->  // [RQ13]
		($past(health_next) != $past(health_reg)) || $past(safe_done))
		else $error("health event without cause");

	group_evt_a: assert property (event_o.group_layout_event |->  // [RQ16]
		event_o.group_presence_bitmap != $past(group_map_reg))
		else $error("group event without change");

	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");

	restart_pulse_a: assert property (core_restart_o |=> !core_restart_o)  // [RQ9]
		else $error("core restart held too long");

	safe_quiet_a: assert property ((state_reg == ST_SAFE) |->  // [RQ12]
		!tx_inhibit_o && !core_restart_o)
		else $error("safe test disturbed traffic");

	busy_flag_a: assert property ((state_reg != ST_IDLE && timer_reg != 17'h0) |->  // [RQ12]
		selftest_busy_o)
		else $error("busy flag low during test");

	disrupt_c: cover property (state_reg == ST_DISRUPT ##1 state_reg == ST_IDLE);
	safe_c: cover property (safe_done ##1 event_o.health_change_event);
	group_c: cover property (event_o.group_layout_event);
	wrap_c: cover property (coll_count_reg == 32'hffff_ffff ##1 coll_inc);

endmodule // repeater_mgmt

/* File: repeater_mgmt_cfg.svh */
// Purpose: Offsets, codes and timing counts of the repeater management block
// Assumes: 25 MHz clock, Wishbone byte addresses, 32-bit data
// Notes:   Definitions only
`ifndef REPEATER_MGMT_CFG_SVH
`define REPEATER_MGMT_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define GROUP_CAP        8
`define PORT_CAP         16
`define GROUP_IDX_W      3
`define TEXT_MAX         8'hff

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_IDENT        12'h000
`define OFS_CLASS        12'h004
`define OFS_GROUP_CAP    12'h008
`define OFS_GROUP_MAP    12'h00c
`define OFS_HEALTH       12'h010
`define OFS_TEXT_LEN     12'h014
`define OFS_DATA_LEN     12'h018
`define OFS_COLL_COUNT   12'h01c
`define OFS_ACTION       12'h020
`define OFS_STATUS       12'h024
`define OFS_GROUP_BASE   4'h1
`define OFS_PORTMAP_BASE 4'h2
`define OFS_TEXT_BASE    2'h1
`define OFS_DATA_BASE    2'h2

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define ACT_RESET_BIT    0
`define ACT_SAFE_BIT     1
`define IDENT_VALUE      32'h0000_0001  // Arbitrary value, names no maker or part
`define CLASS_UNKNOWN    32'h0000_0000
`define CLASS_OTHER      32'h0000_0001
`define CLASS_TEN        32'h0000_0009
`define CLASS_FAST_ONE   32'h0000_010f
`define CLASS_FAST_TWO   32'h0000_0110
`define PRINT_LOW        8'h20
`define PRINT_HIGH       8'h7e

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    40
`define DISRUPT_TIME_NS  100000
`define SAFE_TIME_NS     20000
`define DISRUPT_CYCLES   (`DISRUPT_TIME_NS / `CLK_PERIOD_NS)
`define SAFE_CYCLES      (`SAFE_TIME_NS / `CLK_PERIOD_NS)

`endif

/* File: repeater_mgmt_pkg.sv */
// Purpose: Types shared by the repeater management block and its bench
// Assumes: Constants live in repeater_mgmt_cfg.svh
// Notes:   Health codes are the values software reads
package repeater_mgmt_pkg;

	typedef enum logic [2:0] {
		HEALTH_OTHER    = 3'h1,
		HEALTH_OK       = 3'h2,
		HEALTH_REPEATER = 3'h3,
		HEALTH_GROUP    = 3'h4,
		HEALTH_PORT     = 3'h5,
		HEALTH_GENERAL  = 3'h6
	} health_e;

	typedef enum logic [2:0] {
		CLASS_SEL_UNKNOWN = 3'h0,
		CLASS_SEL_TEN     = 3'h1,
		CLASS_SEL_FAST1   = 3'h2,
		CLASS_SEL_FAST2   = 3'h3,
		CLASS_SEL_OTHER   = 3'h4
	} class_sel_e;

	typedef struct packed {
		logic repeater_fail;
		logic group_fail;
		logic port_fail;
		logic general_fail;
		logic unknown;
	} fault_s;

	typedef struct packed {
		logic       coll_enter;
		logic       from_one_left;
		logic       jam_enter;
		logic       multi_active;
	} core_s;

	typedef struct packed {
		logic       health_change_event;
		logic       reset_done_event;
		logic       group_layout_event;
		health_e    health_condition;
		logic [7:0] group_presence_bitmap;
	} event_s;

endpackage

/* File: testbench.sv */
// Purpose: Self-checking bench for the repeater management block
// Assumes: Classic Wishbone with one wait state, 25 MHz clock, sync reset
// Notes:   Random stimulus from a fixed seed; event pulses are counted by a monitor
`include "repeater_mgmt_cfg.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                            clk_i;
	logic                            rst_i;
	logic [11:0]                     adr_i;
	logic [31:0]                     dat_i;
	logic [31:0]                     dat_o;
	logic [3:0]                      sel_i;
	logic                            we_i, cyc_i, stb_i, ack_o;
	logic                            core_restart_o, tx_inhibit_o, selftest_busy_o;
	repeater_mgmt_pkg::class_sel_e   class_sel_i;
	logic [`GROUP_CAP-1:0]           group_present_i;
	logic [`GROUP_CAP*`PORT_CAP-1:0] port_present_i;
	repeater_mgmt_pkg::fault_s       fault_i;
	repeater_mgmt_pkg::core_s        core_i;
	repeater_mgmt_pkg::event_s       event_o;
	int                              n_fail, comparisons, seed, k, idx;
	int                              n_hev, n_rev, n_gev, n_restart, n_inh, n_busy;
	int                              exp_hev, exp_gev, exp_coll, r0, h0, i0, b0, s0;
	repeater_mgmt_pkg::health_e      last_hev, last_rev, cur_h;
	logic [7:0]                      last_gmap, gm, gprev, c, tt [8], dd [8];
	logic [4:0]                      f;
	logic [3:0]                      cv;
	logic [127:0]                    pp;
	logic [31:0]                     rd;

	repeater_mgmt dut (
		.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
		.we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
		.class_sel_i(class_sel_i), .group_present_i(group_present_i),
		.port_present_i(port_present_i), .fault_i(fault_i), .core_i(core_i),
		.core_restart_o(core_restart_o), .tx_inhibit_o(tx_inhibit_o),
		.selftest_busy_o(selftest_busy_o), .event_o(event_o)
	);

	// ----------------------------------------------------------------
	// Expectations
	// ----------------------------------------------------------------
	function automatic repeater_mgmt_pkg::health_e prio(input logic [4:0] v);
		repeater_mgmt_pkg::fault_s x;
		x = repeater_mgmt_pkg::fault_s'(v);
		if (x.repeater_fail) return repeater_mgmt_pkg::HEALTH_REPEATER;
		if (x.group_fail) return repeater_mgmt_pkg::HEALTH_GROUP;
		if (x.port_fail) return repeater_mgmt_pkg::HEALTH_PORT;
		if (x.general_fail) return repeater_mgmt_pkg::HEALTH_GENERAL;
		if (x.unknown) return repeater_mgmt_pkg::HEALTH_OTHER;
		return repeater_mgmt_pkg::HEALTH_OK;
	endfunction

	function automatic logic [31:0] class_code(input int s);
		case (s)
			1: return 32'h0000_0009;
			2: return 32'h0000_010f;
			3: return 32'h0000_0110;
			4: return 32'h0000_0001;
			default: return 32'h0000_0000;
		endcase
	endfunction

	// Unknown and other classes never count
	function automatic logic counts(input int s, input logic [3:0] v);
		repeater_mgmt_pkg::core_s x;
		x = repeater_mgmt_pkg::core_s'(v);
		if (s == 1) return x.coll_enter & !x.from_one_left;
		if (s == 2 || s == 3) return x.jam_enter & x.multi_active;
		return 1'b0;
	endfunction

	// ----------------------------------------------------------------
	// Bus master and verdict
	// ----------------------------------------------------------------
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			$display("wrong value at %0t: no bus answer", $time);
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, monitor, watchdog
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// Counters are checked by the sequence only at falling edges to avoid races
	always @(posedge clk_i) begin
		if (rst_i === 1'b0) begin
			if (event_o.health_change_event === 1'b1) begin
				n_hev++;
				last_hev = event_o.health_condition;
			end
			if (event_o.reset_done_event === 1'b1) begin
				n_rev++;
				last_rev = event_o.health_condition;
			end
			if (event_o.group_layout_event === 1'b1) begin
				n_gev++;
				last_gmap = event_o.group_presence_bitmap;
			end
			if (core_restart_o === 1'b1) n_restart++;
			if (tx_inhibit_o === 1'b1) n_inh++;
			if (selftest_busy_o === 1'b1) n_busy++;
		end
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		$display("wrong value at %0t: watchdog expired", $time);
		summarize();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 49;
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
		sel_i = 4'hf;
		class_sel_i = repeater_mgmt_pkg::CLASS_SEL_TEN;
		gprev = 8'h5a;
		group_present_i = gprev;
		port_present_i = {4{$random(seed)}};
		fault_i = '0;
		core_i = '0;
		cur_h = repeater_mgmt_pkg::HEALTH_OK;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (20) @(negedge clk_i);
		`CHK(n_rev, 1)
		`CHK(n_hev + n_gev, 0)
		rchk(`OFS_GROUP_CAP, 32'h0000_0008);
		wb(1'b1, `OFS_GROUP_CAP, 32'h0000_0003);
		rchk(`OFS_GROUP_CAP, 32'h0000_0008);
		rchk(12'hffc, 32'h0000_0000);
		rchk(`OFS_COLL_COUNT, 32'h0000_0000);
		wb(1'b1, `OFS_TEXT_LEN, 32'h0000_00ff);
		rchk(`OFS_TEXT_LEN, 32'h0000_00ff);
		// Group layout: all absent, all present, then random
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			gm = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			pp = {4{$random(seed)}};
			group_present_i <= gm;
			port_present_i <= pp;
			repeat (8) @(negedge clk_i);
			if (gm !== gprev) exp_gev++;
			gprev = gm;
			`CHK(n_gev, exp_gev)
			`CHK(last_gmap, gm)
			rchk(`OFS_GROUP_MAP, {24'h0, gm});
			for (int g = 0; g < 8; g++) begin
				rchk({`OFS_GROUP_BASE, 8'(g * 4)}, {16'(g + 1), 16'h0010});
				rchk({`OFS_PORTMAP_BASE, 8'(g * 4)}, {16'h0, pp[16 * g +: 16]});
			end
		end
		// Each priority level on top first, then random fault mixes
		for (int i = 0; i < 24; i++) begin
			@(posedge clk_i);
			f = (i < 6) ? 5'h1f >> i : 5'($random(seed));
			fault_i <= repeater_mgmt_pkg::fault_s'(f);
			repeat (4) @(negedge clk_i);
			if (prio(f) !== cur_h) exp_hev++;
			cur_h = prio(f);
			`CHK(n_hev, exp_hev)
			`CHK(last_hev, cur_h)
			rchk(`OFS_HEALTH, {29'h0, cur_h});
		end
		// Text refuses non-printable characters; last slot is index 255
		for (int i = 0; i < 8; i++) begin
			idx = (i == 7) ? 255 : i;
			c = (i == 0) ? 8'h20 : (i == 1) ? 8'h7e : 8'({$random(seed)} % 94) + 8'h21;
			tt[i] = c;
			dd[i] = 8'($random(seed));
			wb(1'b1, {`OFS_TEXT_BASE, 10'(idx * 4)}, {24'h0, c});
			wb(1'b1, {`OFS_TEXT_BASE, 10'(idx * 4)}, i[0] ? 32'h0000_007f : 32'h0000_0019);
			wb(1'b1, {`OFS_DATA_BASE, 10'(idx * 4)}, {24'h0, dd[i]});
		end
		for (int i = 0; i < 8; i++) begin
			idx = (i == 7) ? 255 : i;
			rchk({`OFS_TEXT_BASE, 10'(idx * 4)}, {24'h0, tt[i]});
			rchk({`OFS_DATA_BASE, 10'(idx * 4)}, {24'h0, dd[i]});
		end
		// Collision counting for every class code
		for (int s = 0; s < 5; s++) begin
			@(posedge clk_i);
			class_sel_i <= repeater_mgmt_pkg::class_sel_e'(s[2:0]);
			rchk(`OFS_CLASS, class_code(s));
			for (int n = 0; n < 20; n++) begin
				@(posedge clk_i);
				cv = 4'($random(seed));
				core_i <= repeater_mgmt_pkg::core_s'(cv);
				if (counts(s, cv)) exp_coll++;
				@(posedge clk_i);
				core_i <= '0;
			end
			rchk(`OFS_COLL_COUNT, 32'(exp_coll));
		end
		// Disruptive reset; both action bits set, reset must win
		{r0, h0, i0, b0, s0} = {n_rev, n_hev, n_inh, n_busy, n_restart};
		wb(1'b1, `OFS_ACTION, 32'h0000_0003);
		rchk(`OFS_STATUS, 32'h0000_0002);
		wb(1'b1, `OFS_ACTION, 32'h0000_0002);
		rchk(`OFS_COLL_COUNT, 32'(exp_coll));
		for (k = 0; k < 3000 && n_rev == r0; k++) @(negedge clk_i);
		repeat (4) @(negedge clk_i);
		`CHK(n_rev - r0, 1)
		`CHK(last_rev, cur_h)
		`CHK(n_restart - s0, 1)
		`CHK(n_inh - i0, 2500)
		`CHK(n_busy - b0, 2500)
		`CHK(n_hev, h0)
		rchk(`OFS_COLL_COUNT, 32'(exp_coll));
		rchk({`OFS_TEXT_BASE, 10'h0}, {24'h0, tt[0]});
		rchk(`OFS_HEALTH, {29'h0, cur_h});
		// Safe self-test
		{h0, i0, b0, s0} = {n_hev, n_inh, n_busy, n_restart};
		wb(1'b1, `OFS_ACTION, 32'h0000_0002);
		rchk(`OFS_STATUS, 32'h0000_0004);
		for (k = 0; k < 1000 && n_hev == h0; k++) @(negedge clk_i);
		repeat (4) @(negedge clk_i);
		`CHK(n_hev - h0, 1)
		`CHK(last_hev, cur_h)
		`CHK(n_inh - i0, 0)
		`CHK(n_busy - b0, 500)
		`CHK(n_restart - s0, 0)
		rchk(`OFS_STATUS, 32'h0000_0001);
		rchk(`OFS_COLL_COUNT, 32'(exp_coll));
		rchk({`OFS_DATA_BASE, 10'h0}, {24'h0, dd[0]});
		summarize();
	end
endmodule // testbench
